// [core/scr_pkg.sv]
// constants shared by the scaler control/status register bank
package scr_pkg;
  localparam logic [7:0] SCR_GLOBAL_ADDR = 8'h88;
  localparam logic [7:0] SCR_STATUS_ADDR = 8'h8F;
  localparam logic [7:0] SCR_TASK_A_ADDR = 8'h90;
  localparam logic [7:0] SCR_TASK_B_ADDR = 8'hC0;
  localparam logic [7:0] SCR_GLOBAL_RST = 8'h00;
  localparam logic [7:0] SCR_TASK_RST = 8'h00;
  localparam int SCR_SEL_HI = 7;
  localparam int SCR_SEL_LO = 6;
  localparam int SCR_SCALER_SOFT_RESET_N_BIT = 5;
  localparam int SCR_MARK_BIT = 4;
  localparam int SCR_AUDIO_PD_BIT = 3;
  localparam int SCR_SCALER_PD_BIT = 1;
  localparam int SCR_DEC_PD_BIT = 0;
  localparam int SCR_OFID_SEL_BIT = 6;
  localparam int SCR_POL_BIT = 7;
  localparam int SCR_SKIP_HI = 5;
  localparam int SCR_SKIP_LO = 3;
  localparam logic [1:0] SCR_IPE_PIN_LOW = 2'h2;
  localparam logic [1:0] SCR_IPE_PIN_HIGH = 2'h3;
  localparam logic [1:0] SCR_IPE_SW_ON = 2'h1;
  localparam logic [2:0] SCR_SKIP_ZERO = 3'h0;
  localparam logic [8:0] SCR_ADC_ZERO = 9'h000;
endpackage : scr_pkg

// [core/scr_regs.sv]
// scaler control/status register bank: global byte, status, task sets
`timescale 1ns/1ps
`default_nettype none
module scr_regs
  import scr_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WR_DATA,
  output logic [7:0] RD_DATA,
  input wire logic [8:0] ADC_CH1,
  input wire logic [8:0] ADC_CH2,
  input wire logic [8:0] ADC_CH3,
  input wire logic [8:0] ADC_CH4,
  output logic [8:0] ADC_TEST_PORT,
  input wire logic XPORT_TRISTATE_PIN,
  input wire logic IPORT_TRISTATE_PIN,
  input wire logic [1:0] IPORT_ENABLE_MODE,
  input wire logic SCALER_SRC_XPORT,
  input wire logic IMAGE_PORT_CLOCK_SRC_XPORT,
  input wire logic FIFO_ALMOST_FILLED,
  input wire logic FIFO_OVERFLOW,
  input wire logic RATE_CONFLICT,
  input wire logic INPUT_FIELD_ID,
  input wire logic FIELD_START,
  input wire logic TASK_A_SELECT,
  input wire logic TASK_B_SELECT,
  input wire logic TASK_B_ACTIVE,
  output logic SCALER_RUN,
  output logic DECODER_POWER_DOWN,
  output logic SCALER_POWER_DOWN,
  output logic AUDIO_CLOCK_ENABLE,
  output logic IMAGE_PORT_ENABLE,
  output logic OUTPUT_FIELD_ID,
  output logic SAV_EAV_D7,
  output logic TASK_A_FIRE,
  output logic TASK_B_FIRE
);
  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    logic [7:0] global_ctrl;
    logic [7:0] rd_data;
    logic [8:0] adc_out;
    logic [1:0] xport_tristate_pin_flag_sync;
    logic [1:0] iport_tristate_pin_flag_sync;
    logic [1:0] fidi_sync;
    logic [1:0] fstart_sync;
    logic fstart_d;
    logic [1:0] fifo_almost_filled_flag_sync;
    logic [1:0] fifo_overflow_flag_sync;
    logic [1:0] conf_sync;
    logic err_flag;
    logic run;
    logic dec_pd;
    logic scl_pd;
    logic aud_en;
    logic img_en;
    logic ofid;
    logic sav_d7;
    logic fire_a;
    logic fire_b;
  } scr_state_type;

  scr_state_type st_r;
  scr_state_type st_nxt;

  logic [7:0] task_a_byte;
  logic [7:0] task_b_byte;
  logic fid_a;
  logic fid_b;
  logic d7_a;
  logic d7_b;
  logic fire_a;
  logic fire_b;
  logic field_pulse;
  logic scaler_alive;
  logic wr_a;
  logic wr_b;

  // ************************************************
  // derived control
  // ************************************************
  // scaler survives decoder power-down only when fed and clocked by x-port
  assign scaler_alive = st_r.global_ctrl[SCR_SCALER_SOFT_RESET_N_BIT] &&
                        !st_r.global_ctrl[SCR_SCALER_PD_BIT] &&
                        (!st_r.global_ctrl[SCR_DEC_PD_BIT] ||
                         (SCALER_SRC_XPORT && IMAGE_PORT_CLOCK_SRC_XPORT));
  assign field_pulse = st_r.fstart_sync[1] && !st_r.fstart_d;
  assign wr_a = WR_EN && (ADDR == SCR_TASK_A_ADDR);
  assign wr_b = WR_EN && (ADDR == SCR_TASK_B_ADDR);

  scr_task_ctrl u_task_a (
    .clock(CLOCK),
    .rst_n(RST_N),
    .run(st_r.run),
    .wr_en(wr_a),
    .wr_data(WR_DATA),
    .field_start(field_pulse),
    .task_select(TASK_A_SELECT),
    .input_fid(st_r.fidi_sync[1]),
    .ctrl_byte(task_a_byte),
    .task_fire(fire_a),
    .output_fid(fid_a),
    .sav_d7(d7_a)
  );

  scr_task_ctrl u_task_b (
    .clock(CLOCK),
    .rst_n(RST_N),
    .run(st_r.run),
    .wr_en(wr_b),
    .wr_data(WR_DATA),
    .field_start(field_pulse),
    .task_select(TASK_B_SELECT),
    .input_fid(st_r.fidi_sync[1]),
    .ctrl_byte(task_b_byte),
    .task_fire(fire_b),
    .output_fid(fid_b),
    .sav_d7(d7_b)
  );

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    st_nxt = st_r;
    // pins from outside the clock domain pass two flops
    st_nxt.xport_tristate_pin_flag_sync = {st_r.xport_tristate_pin_flag_sync[0], XPORT_TRISTATE_PIN};
    st_nxt.iport_tristate_pin_flag_sync = {st_r.iport_tristate_pin_flag_sync[0], IPORT_TRISTATE_PIN};
    st_nxt.fidi_sync = {st_r.fidi_sync[0], INPUT_FIELD_ID};
    st_nxt.fstart_sync = {st_r.fstart_sync[0], FIELD_START};
    st_nxt.fstart_d = st_r.fstart_sync[1];
    st_nxt.fifo_almost_filled_flag_sync = {st_r.fifo_almost_filled_flag_sync[0], FIFO_ALMOST_FILLED};
    st_nxt.fifo_overflow_flag_sync = {st_r.fifo_overflow_flag_sync[0], FIFO_OVERFLOW};
    st_nxt.conf_sync = {st_r.conf_sync[0], RATE_CONFLICT};
    if (WR_EN && (ADDR == SCR_GLOBAL_ADDR)) begin
      st_nxt.global_ctrl = WR_DATA;
    end
    // writes to the status address fall through untouched
    // formatter error follows the live conflict condition
    st_nxt.err_flag = st_r.conf_sync[1] && scaler_alive;
    st_nxt.run = scaler_alive;
    st_nxt.dec_pd = st_r.global_ctrl[SCR_DEC_PD_BIT];
    st_nxt.scl_pd = st_r.global_ctrl[SCR_SCALER_PD_BIT];
    st_nxt.aud_en = !st_r.global_ctrl[SCR_AUDIO_PD_BIT];
    unique case (st_r.global_ctrl[SCR_SEL_HI:SCR_SEL_LO])
      2'h0: st_nxt.adc_out = ADC_CH1;
      2'h1: st_nxt.adc_out = ADC_CH2;
      2'h2: st_nxt.adc_out = ADC_CH3;
      2'h3: st_nxt.adc_out = ADC_CH4;
    endcase
    // image port: stopped with the scaler, then per enable mode
    unique case (IPORT_ENABLE_MODE)
      SCR_IPE_PIN_LOW: st_nxt.img_en = scaler_alive &&
                                       !st_r.iport_tristate_pin_flag_sync[1];
      SCR_IPE_PIN_HIGH: st_nxt.img_en = scaler_alive &&
                                        st_r.iport_tristate_pin_flag_sync[1];
      SCR_IPE_SW_ON: st_nxt.img_en = scaler_alive;
      default: st_nxt.img_en = 1'b0;
    endcase
    st_nxt.ofid = TASK_B_ACTIVE ? fid_b : fid_a;
    st_nxt.sav_d7 = TASK_B_ACTIVE ? d7_b : d7_a;
    st_nxt.fire_a = fire_a;
    st_nxt.fire_b = fire_b;
    // read data sampled the cycle of the read: live flags
    st_nxt.rd_data = 8'h00;
    if (RD_EN) begin
      unique case (ADDR)
        SCR_GLOBAL_ADDR: st_nxt.rd_data = st_r.global_ctrl;
        SCR_STATUS_ADDR: st_nxt.rd_data = {st_r.xport_tristate_pin_flag_sync[1],
                                           st_r.iport_tristate_pin_flag_sync[1],
                                           st_r.fifo_almost_filled_flag_sync[1],
                                           st_r.fifo_overflow_flag_sync[1],
                                           st_r.global_ctrl[SCR_MARK_BIT],
                                           st_r.err_flag,
                                           st_r.fidi_sync[1],
                                           st_r.ofid};
        SCR_TASK_A_ADDR: st_nxt.rd_data = task_a_byte;
        SCR_TASK_B_ADDR: st_nxt.rd_data = task_b_byte;
        default: st_nxt.rd_data = 8'h00;
      endcase
    end
    if (!RST_N) begin
      st_nxt = '0;
      st_nxt.global_ctrl = SCR_GLOBAL_RST;
      st_nxt.adc_out = SCR_ADC_ZERO;
      st_nxt.aud_en = 1'b1;
      st_nxt.sav_d7 = 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    st_r <= st_nxt;
  end

  // ************************************************
  // outputs, each from a flop
  // ************************************************
  assign RD_DATA = st_r.rd_data;
  assign ADC_TEST_PORT = st_r.adc_out;
  assign SCALER_RUN = st_r.run;
  assign DECODER_POWER_DOWN = st_r.dec_pd;
  assign SCALER_POWER_DOWN = st_r.scl_pd;
  assign AUDIO_CLOCK_ENABLE = st_r.aud_en;
  assign IMAGE_PORT_ENABLE = st_r.img_en;
  assign OUTPUT_FIELD_ID = st_r.ofid;
  assign SAV_EAV_D7 = st_r.sav_d7;
  assign TASK_A_FIRE = st_r.fire_a;
  assign TASK_B_FIRE = st_r.fire_b;
endmodule : scr_regs
`default_nettype wire

// [core/scr_task_ctrl.sv]
// one task register set: control byte, field skipping, task flag
`timescale 1ns/1ps
`default_nettype none
module scr_task_ctrl
  import scr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic field_start,
  input wire logic task_select,
  input wire logic input_fid,
  output logic [7:0] ctrl_byte,
  output logic task_fire,
  output logic output_fid,
  output logic sav_d7
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [2:0] skip_cnt;
    logic flag;
    logic armed;
    logic fire;
  } scr_task_state_type;

  scr_task_state_type st_r;
  scr_task_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.fire = 1'b0;
    if (wr_en) begin
      st_nxt.ctrl = wr_data;
    end
    if (!run) begin
      // idle scaler: drop any pending activation, flag keeps its value
      st_nxt.armed = 1'b0;
      st_nxt.skip_cnt = SCR_SKIP_ZERO;
    end else if (task_select && !st_r.armed) begin
      st_nxt.armed = 1'b1;
      st_nxt.skip_cnt = st_r.ctrl[SCR_SKIP_HI:SCR_SKIP_LO];
    end else if (st_r.armed && field_start) begin
      if (st_r.skip_cnt == SCR_SKIP_ZERO) begin
        st_nxt.armed = 1'b0;
        st_nxt.fire = 1'b1;
        st_nxt.flag = ~st_r.flag;
      end else begin
        st_nxt.skip_cnt = st_r.skip_cnt - 3'h1;
      end
    end
    if (!rst_n) begin
      st_nxt = '0;
      st_nxt.ctrl = SCR_TASK_RST;
    end
  end

  always_ff @(posedge clock) begin
    st_r <= st_nxt;
  end

  // task flag level: polarity bit zero means flag reads one at rest
  logic flag_level;
  assign flag_level = st_r.flag ^ ~st_r.ctrl[SCR_POL_BIT];
  assign ctrl_byte = st_r.ctrl;
  assign task_fire = st_r.fire;
  assign sav_d7 = ~st_r.ctrl[SCR_POL_BIT];
  assign output_fid = st_r.ctrl[SCR_OFID_SEL_BIT] ? flag_level
                                                  : input_fid;
endmodule : scr_task_ctrl
`default_nettype wire

// [testbench/scr_host_model.sv]
// host model issuing single-byte register accesses
`timescale 1ns/1ps
`default_nettype none
module scr_host_model (
  input wire logic clock,
  input wire logic [7:0] rd_data,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wr_data
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr
  // read byte stands one cycle only, so it is taken right after the edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd
endmodule : scr_host_model
`default_nettype wire

// [testbench/scr_regs_asserts.sv]
// concurrent checks on the scaler register bank ports
`timescale 1ns/1ps
`default_nettype none
module scr_regs_asserts
  import scr_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic [7:0] RD_DATA,
  input wire logic [1:0] IPORT_ENABLE_MODE,
  input wire logic SCALER_RUN,
  input wire logic SCALER_POWER_DOWN,
  input wire logic AUDIO_CLOCK_ENABLE,
  input wire logic IMAGE_PORT_ENABLE,
  input wire logic TASK_A_FIRE
);
  // ***
  // global byte shadow
  // ***
  logic [7:0] glb_r;
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      glb_r <= 8'h00;
    end else if (WR_EN && ADDR == SCR_GLOBAL_ADDR) begin
      glb_r <= WR_DATA;
    end
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  sequence s_wr_glb;
    WR_EN && ADDR == SCR_GLOBAL_ADDR;
  endsequence
  sequence s_wr_stat;
    WR_EN && ADDR == SCR_STATUS_ADDR;
  endsequence
  sequence s_rd_stat;
    RD_EN && !WR_EN && ADDR == SCR_STATUS_ADDR;
  endsequence
  property p_mark_echo;
    s_rd_stat |=> RD_DATA[3] == $past(glb_r[4]);
  endproperty
  a_mark_echo: assert property (p_mark_echo) else $error("bad echo");
  // control byte lands one edge after the write, the output one edge later
  property p_audio;
    s_wr_glb |-> ##2 AUDIO_CLOCK_ENABLE == !$past(WR_DATA[3], 2);
  endproperty
  a_audio: assert property (p_audio) else $error("bad audio");
  property p_scaler_pd;
    SCALER_POWER_DOWN [*3] |-> !SCALER_RUN && !IMAGE_PORT_ENABLE;
  endproperty
  a_scaler_pd: assert property (p_scaler_pd) else $error("pd run");
  property p_softrst;
    !glb_r[5] [*2] |-> !SCALER_RUN;
  endproperty
  a_softrst: assert property (p_softrst) else $error("not idle");
  property p_iport_off;
    IPORT_ENABLE_MODE == 2'h0 [*3] |-> !IMAGE_PORT_ENABLE;
  endproperty
  a_iport_off: assert property (p_iport_off) else $error("image on");
  // a global write just before would still be settling into the outputs
  property p_status_ro;
    !(WR_EN && ADDR == SCR_GLOBAL_ADDR) ##1 s_wr_stat |=>
      $stable(SCALER_POWER_DOWN) && $stable(AUDIO_CLOCK_ENABLE);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("ro hit");
  property p_fire;
    TASK_A_FIRE |=> !TASK_A_FIRE;
  endproperty
  a_fire: assert property (p_fire) else $error("long fire");
  property p_rd_idle;
    !RD_EN |=> RD_DATA == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray data");
endmodule : scr_regs_asserts
bind scr_regs scr_regs_asserts scr_regs_asserts_inst (.CLOCK(CLOCK),
  .RST_N(RST_N), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR),
  .WR_DATA(WR_DATA), .RD_DATA(RD_DATA), .IPORT_ENABLE_MODE(IPORT_ENABLE_MODE),
  .SCALER_RUN(SCALER_RUN), .SCALER_POWER_DOWN(SCALER_POWER_DOWN),
  .AUDIO_CLOCK_ENABLE(AUDIO_CLOCK_ENABLE),
  .IMAGE_PORT_ENABLE(IMAGE_PORT_ENABLE), .TASK_A_FIRE(TASK_A_FIRE));
`default_nettype wire

// [testbench/tb_top.sv]
// testbench for the scaler control/status register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import scr_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, we, re, xp = 0, ip = 0, sx = 0, ix = 0;
  logic fifo_almost_filled_flag = 0, fifo_overflow_flag = 0, rc = 0, ifid = 0, fst = 0, sa = 0, sb = 0;
  logic bact = 0, run, dpd, spd, aud, img, ofid, sav, fa, fb;
  logic [1:0] ipe = 2'h0;
  logic [7:0] ad, wd, rdd, d;
  logic [8:0] adcp;
  logic [8:0] ch [4] = '{9'h101, 9'h0A2, 9'h153, 9'h1FC};
  int bad_count = 0, check_count = 0;
  always #25 clk = ~clk;
  scr_host_model scr_host_model_inst (.clock(clk), .rd_data(rdd),
    .wr_en(we), .rd_en(re), .addr(ad), .wr_data(wd));
  scr_regs scr_regs_inst (.CLOCK(clk), .RST_N(rst_n), .WR_EN(we),
    .RD_EN(re), .ADDR(ad), .WR_DATA(wd), .RD_DATA(rdd), .ADC_CH1(ch[0]),
    .ADC_CH2(ch[1]), .ADC_CH3(ch[2]), .ADC_CH4(ch[3]), .ADC_TEST_PORT(adcp),
    .XPORT_TRISTATE_PIN(xp), .IPORT_TRISTATE_PIN(ip),
    .IPORT_ENABLE_MODE(ipe), .SCALER_SRC_XPORT(sx), .IMAGE_PORT_CLOCK_SRC_XPORT(ix),
    .FIFO_ALMOST_FILLED(fifo_almost_filled_flag), .FIFO_OVERFLOW(fifo_overflow_flag), .RATE_CONFLICT(rc),
    .INPUT_FIELD_ID(ifid), .FIELD_START(fst), .TASK_A_SELECT(sa),
    .TASK_B_SELECT(sb), .TASK_B_ACTIVE(bact), .SCALER_RUN(run),
    .DECODER_POWER_DOWN(dpd), .SCALER_POWER_DOWN(spd),
    .AUDIO_CLOCK_ENABLE(aud), .IMAGE_PORT_ENABLE(img),
    .OUTPUT_FIELD_ID(ofid), .SAV_EAV_D7(sav), .TASK_A_FIRE(fa),
    .TASK_B_FIRE(fb));
  // ***
  // checking and closing
  // ***
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // ***
  // scenarios
  // ***
  task automatic t_reset;
    scr_host_model_inst.rd(SCR_STATUS_ADDR, d);
    chk(d[3], 1'b0);
    chk({aud, sav, run}, 3'h6);
  endtask : t_reset
  task automatic t_global;
    // image port on by software, so it stops whenever the scaler is not alive
    ipe <= 2'h1;
    for (int s = 0; s < 4; s++) begin
      // soft reset, marker, audio and scaler power-down all set
      scr_host_model_inst.wr(SCR_GLOBAL_ADDR, {s[1:0], 6'h3A});
      repeat (3) @(posedge clk);
      chk(adcp, ch[s]);
      chk({aud, spd, img}, 3'h2);
      scr_host_model_inst.rd(SCR_GLOBAL_ADDR, d);
      chk(d, {s[1:0], 6'h3A});
    end
  endtask : t_global
  task automatic t_power;
    scr_host_model_inst.wr(SCR_GLOBAL_ADDR, 8'h21);
    repeat (3) @(posedge clk);
    chk({dpd, run}, 2'h2);
    sx <= 1'b1;
    ix <= 1'b1;
    repeat (3) @(posedge clk);
    chk(run, 1'b1);
  endtask : t_power
  task automatic t_status(input logic [5:0] pins, input logic [7:0] exp);
    scr_host_model_inst.wr(SCR_GLOBAL_ADDR, 8'h30);
    {xp, ip, fifo_almost_filled_flag, fifo_overflow_flag, rc, ifid} <= pins;
    ipe <= 2'h3;
    repeat (6) @(posedge clk);
    chk(img, pins[4]);
    scr_host_model_inst.rd(SCR_STATUS_ADDR, d);
    chk(d, exp);
    scr_host_model_inst.wr(SCR_STATUS_ADDR, 8'hFF);
    scr_host_model_inst.rd(SCR_STATUS_ADDR, d);
    chk(d, exp);
    ipe <= 2'h2;
    repeat (3) @(posedge clk);
    chk(img, !pins[4]);
    ipe <= 2'h1;
    repeat (3) @(posedge clk);
    chk(img, 1'b1);
  endtask : t_status
  task automatic t_task(input logic b, input logic [2:0] skip);
    logic f0, s0;
    logic [7:0] ra;
    int na, nb;
    logic [7:0] exp_fire;
    ra = b ? SCR_TASK_B_ADDR : SCR_TASK_A_ADDR;
    bact <= b;
    scr_host_model_inst.wr(ra, {2'h1, skip, 3'h0});
    repeat (3) @(posedge clk);
    f0 = ofid;
    s0 = sav;
    sa <= !b;
    sb <= b;
    @(posedge clk);
    {sa, sb} <= 2'h0;
    for (int f = 0; f <= skip; f++) begin
      na = 0;
      nb = 0;
      for (int c = 0; c < 12; c++) begin
        fst <= c < 6;
        @(posedge clk);
        na += fa;
        nb += fb;
      end
      exp_fire = b ? {4'h0, 4'(f == skip)} : {4'(f == skip), 4'h0};
      chk({na[3:0], nb[3:0]}, exp_fire);
    end
    chk(ofid, !f0);
    scr_host_model_inst.wr(ra, {2'h3, skip, 3'h0});
    repeat (3) @(posedge clk);
    chk(sav, !s0);
  endtask : t_task
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_global();
    t_power();
    t_status(6'h2B, 8'hAF);
    t_status(6'h14, 8'h58);
    t_task(1'b0, 3'h7);
    t_task(1'b1, 3'h0);
    end_of_test();
  end
  // run needs about two hundred and ten cycles; this is a generous ceiling
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
